/* File: design/icfl_regs.svh */
// Register map, field positions, reset values and vectors of the interrupt flag logic
`ifndef ICFL_REGS_SVH
`define ICFL_REGS_SVH
// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define ICFL_OFF_MAIN 8'h00
`define ICFL_OFF_EDGE_PRIO 8'h04
`define ICFL_OFF_EXTERNAL 8'h08
`define ICFL_OFF_FLAGS_ONE 8'h0C
`define ICFL_OFF_RESET_CTRL 8'h10
`define ICFL_OFF_PERIPH_EN 8'h14
`define ICFL_OFF_PERIPH_PRIO 8'h18
`define ICFL_OFF_STATUS 8'h1C
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ICFL_MAIN_GLOBAL_HIGH 7
`define ICFL_MAIN_PERIPH_LOW 6
`define ICFL_MAIN_T0_EN 5
`define ICFL_MAIN_X0_EN 4
`define ICFL_MAIN_PC_EN 3
`define ICFL_MAIN_T0_FLAG 2
`define ICFL_MAIN_X0_FLAG 1
`define ICFL_MAIN_PC_FLAG 0
`define ICFL_EP_PULLUP_DIS 7
`define ICFL_EP_X0_EDGE 6
`define ICFL_EP_X1_EDGE 5
`define ICFL_EP_X2_EDGE 4
`define ICFL_EP_T0_PRIO 2
`define ICFL_EP_PC_PRIO 0
`define ICFL_EX_X2_PRIO 7
`define ICFL_EX_X1_PRIO 6
`define ICFL_EX_X2_EN 4
`define ICFL_EX_X1_EN 3
`define ICFL_EX_X2_FLAG 1
`define ICFL_EX_X1_FLAG 0
`define ICFL_F1_PARALLEL 7
`define ICFL_F1_CONVERTER 6
`define ICFL_F1_RECEIVE 5
`define ICFL_F1_TRANSMIT 4
`define ICFL_F1_SYNC_SERIAL 3
`define ICFL_F1_CAPCOMP 2
`define ICFL_F1_TIMER_TWO 1
`define ICFL_F1_TIMER_ONE 0
`define ICFL_RC_PRIO_EN 7
// ----------------------------------------------------------------
// Reset values, writable masks and vectors
// ----------------------------------------------------------------
`define ICFL_RST_MAIN 8'h00
`define ICFL_RST_EDGE_PRIO 8'hF5
`define ICFL_RST_EXTERNAL 8'hC0
`define ICFL_RST_FLAGS_ONE 8'h00
`define ICFL_RST_PERIPH_EN 8'h00
`define ICFL_RST_PERIPH_PRIO 8'hFF
`define ICFL_MASK_EDGE_PRIO 8'hF5
`define ICFL_MASK_EXTERNAL 8'hDB
`define ICFL_MASK_FLAGS_ONE 8'hCF
`define ICFL_VEC_HIGH 16'h0008
`define ICFL_VEC_LOW 16'h0018
`define ICFL_RESP_OKAY 2'h0
`define ICFL_RESP_SLVERR 2'h2
`endif

/* File: design/icfl_pkg.sv */
// Types shared by the interrupt flag logic
`default_nettype none
package icfl_pkg;
    // Mode of the capture/compare unit
    typedef enum logic [1:0] {CCP_CAPTURE, CCP_COMPARE, CCP_PWM, CCP_OFF} icfl_ccp_mode_t;
    // Whole state of the block, registered as one word
    typedef struct packed {
        logic [7:0] main_r;
        logic [7:0] edge_prio_r;
        logic [7:0] external_r;
        logic [7:0] flags_one_r;
        logic prio_en;
        logic [7:0] periph_en_r;
        logic [7:0] periph_prio_r;
        logic [2:0] ext_s1;
        logic [2:0] ext_s2;
        logic [2:0] ext_prev;
        logic [3:0] port_s1;
        logic [3:0] port_s2;
        logic [3:0] port_snap;
        logic snap_due;
        logic [3:0] pullup_on;
        logic irq_req;
        logic irq_high;
        logic [15:0] irq_vector;
        logic aw_got;
        logic w_got;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic wr_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } icfl_state_t;
endpackage
`default_nettype wire

/* File: design/icfl_top.sv */
// Interrupt control, edge/priority and peripheral flag registers behind an AXI4-Lite slave
// Notes on behaviour
// (RQ1) Compat mode: global enable gates all interrupts
// (RQ2) Priority mode: top bit gates high-priority interrupts
// (RQ3) Compat mode: peripheral enable gates peripheral interrupts
// (RQ4) Priority mode: bit six gates low-priority interrupts
// (RQ5) Enables for timer zero, ext zero, port change
// (RQ6) Timer zero and ext zero flags are sticky
// (RQ7) Upper port change sets sticky port flag
// (RQ8) Mismatch keeps setting; port read ends it
// (RQ9) Pull-up disable bit overrides per-pin latches
// (RQ10) Edge select: one rising, zero falling
// (RQ11) Priority bit one high, zero low
// (RQ12) Enables for ext one and ext two
// (RQ13) Ext one and ext two flags are sticky
// (RQ14) Unimplemented control bits read as zero
// (RQ15) Flags set regardless of any enable
// (RQ16) Software clears flag before enabling, after servicing
// (RQ17) Parallel port flag; absent on small package
// (RQ18) Converter and sync serial flags are sticky
// (RQ19) Receive flag read-only, mirrors buffer full
// (RQ20) Transmit flag read-only, mirrors buffer empty
// (RQ21) Capcomp flag on capture or compare, not PWM
// (RQ22) Timer two match and timer one overflow flags
// (RQ23) Priority scheme only when priority enable set
// (RQ24) High vector and low vector are distinct
// (RQ25) Compat mode uses the high vector only
// (RQ26) Taking an interrupt clears its global enable
// (RQ27) Writable flags take written value; read-only ignore
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "icfl_regs.svh"
module icfl_top #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins from outside the clock domain
    input wire logic [2:0] ext_irq_pins,
    input wire logic [3:0] upper_port_inputs,
    // Same-clock peripheral events and levels
    input wire logic timer_zero_overflow,
    input wire logic port_read,
    input wire logic [3:0] port_latch,
    input wire logic parallel_port_done,
    input wire logic converter_done,
    input wire logic serial_receive_full,
    input wire logic serial_transmit_empty,
    input wire logic sync_serial_done,
    input wire logic capcomp_event,
    input wire icfl_pkg::icfl_ccp_mode_t capcomp_mode,
    input wire logic timer_two_match,
    input wire logic timer_one_overflow,
    // Processor core side
    input wire logic irq_ack,
    output logic irq_request,
    output logic irq_high,
    output logic [15:0] irq_vector,
    output logic [3:0] pullup_on
);

    icfl_pkg::icfl_state_t st_ff;
    icfl_pkg::icfl_state_t nxt_st;
    logic [2:0] ext_edge;
    logic [2:0] ext_rise_sel;
    logic port_mismatch;
    logic aw_take;
    logic w_take;
    logic [7:0] ev_main;
    logic [7:0] ev_ext;
    logic [7:0] ev_f1;
    logic [7:0] rd_val;
    logic rd_hit;
    logic [7:0] hw_wr;
    logic [4:0] core_pend;
    logic [4:0] core_prio;
    logic [7:0] per_pend;
    logic any_hi;
    logic any_lo;
    logic any_compat;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        hw_wr = 8'h00;
        rd_val = 8'h00;
        rd_hit = 1'b0;
        // Two-flop synchronisers; the edge detector only looks at stage two
        nxt_st.ext_s1 = ext_irq_pins;
        nxt_st.ext_s2 = st_ff.ext_s1;
        nxt_st.ext_prev = st_ff.ext_s2;
        nxt_st.port_s1 = upper_port_inputs;
        nxt_st.port_s2 = st_ff.port_s1;
        ext_rise_sel = {st_ff.edge_prio_r[`ICFL_EP_X2_EDGE], st_ff.edge_prio_r[`ICFL_EP_X1_EDGE],
            st_ff.edge_prio_r[`ICFL_EP_X0_EDGE]};
        for (int i = 0; i < 3; i++)
        begin
            ext_edge[i] = ext_rise_sel[i] ? (st_ff.ext_s2[i] & ~st_ff.ext_prev[i]) :
                (~st_ff.ext_s2[i] & st_ff.ext_prev[i]); // RQ10
        end
        // A port read refreshes the snapshot one cycle later, ending the mismatch
        nxt_st.snap_due = port_read;
        if (st_ff.snap_due)
        begin
            nxt_st.port_snap = st_ff.port_s2; // RQ8
        end
        port_mismatch = (st_ff.port_s2 != st_ff.port_snap); // RQ7 RQ8
        // Hardware set terms, independent of every enable
        ev_main = 8'h00;
        ev_main[`ICFL_MAIN_T0_FLAG] = timer_zero_overflow; // RQ6 RQ15
        ev_main[`ICFL_MAIN_X0_FLAG] = ext_edge[0]; // RQ6
        ev_main[`ICFL_MAIN_PC_FLAG] = port_mismatch; // RQ7
        ev_ext = 8'h00;
        ev_ext[`ICFL_EX_X1_FLAG] = ext_edge[1]; // RQ13
        ev_ext[`ICFL_EX_X2_FLAG] = ext_edge[2]; // RQ13
        ev_f1 = 8'h00;
        ev_f1[`ICFL_F1_PARALLEL] = parallel_port_done & ~SMALL_PACKAGE; // RQ17
        ev_f1[`ICFL_F1_CONVERTER] = converter_done; // RQ18
        ev_f1[`ICFL_F1_SYNC_SERIAL] = sync_serial_done; // RQ18
        ev_f1[`ICFL_F1_CAPCOMP] = capcomp_event &
            ((capcomp_mode == icfl_pkg::CCP_CAPTURE) | (capcomp_mode == icfl_pkg::CCP_COMPARE)); // RQ21
        ev_f1[`ICFL_F1_TIMER_TWO] = timer_two_match; // RQ22
        ev_f1[`ICFL_F1_TIMER_ONE] = timer_one_overflow; // RQ22
        // Write channel: address and data are taken in either order
        aw_take = s_axi_awvalid & st_ff.awready;
        w_take = s_axi_wvalid & st_ff.wready;
        if (aw_take)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.wr_addr = s_axi_awaddr;
        end
        if (w_take)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.wr_data = s_axi_wdata[7:0];
            nxt_st.wr_lane = s_axi_wstrb[0];
        end
        if (st_ff.bvalid & s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (nxt_st.aw_got & nxt_st.w_got & ~nxt_st.bvalid)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `ICFL_RESP_OKAY;
            hw_wr = nxt_st.wr_lane ? nxt_st.wr_data : 8'h00;
            case (nxt_st.wr_addr)
                `ICFL_OFF_MAIN:
                    if (nxt_st.wr_lane) nxt_st.main_r = hw_wr; // RQ5 RQ27
                `ICFL_OFF_EDGE_PRIO:
                    if (nxt_st.wr_lane) nxt_st.edge_prio_r = hw_wr & `ICFL_MASK_EDGE_PRIO; // RQ14
                `ICFL_OFF_EXTERNAL:
                    if (nxt_st.wr_lane) nxt_st.external_r = hw_wr & `ICFL_MASK_EXTERNAL; // RQ12 RQ14
                `ICFL_OFF_FLAGS_ONE:
                    if (nxt_st.wr_lane)
                    begin
                        // Receive and transmit flags keep their mirrored value
                        nxt_st.flags_one_r = (hw_wr & `ICFL_MASK_FLAGS_ONE) |
                            (st_ff.flags_one_r & ~`ICFL_MASK_FLAGS_ONE); // RQ27
                    end
                `ICFL_OFF_RESET_CTRL:
                    if (nxt_st.wr_lane) nxt_st.prio_en = hw_wr[`ICFL_RC_PRIO_EN]; // RQ23
                `ICFL_OFF_PERIPH_EN:
                    if (nxt_st.wr_lane) nxt_st.periph_en_r = hw_wr;
                `ICFL_OFF_PERIPH_PRIO:
                    if (nxt_st.wr_lane) nxt_st.periph_prio_r = hw_wr;
                `ICFL_OFF_STATUS:
                    nxt_st.bresp = `ICFL_RESP_OKAY;
                default:
                    nxt_st.bresp = `ICFL_RESP_SLVERR;
            endcase
        end
        // Hardware sets after the software write, so a same-cycle event wins
        nxt_st.main_r = nxt_st.main_r | ev_main; // RQ6 RQ7 RQ15
        nxt_st.external_r = nxt_st.external_r | ev_ext; // RQ13
        nxt_st.flags_one_r = nxt_st.flags_one_r | ev_f1; // RQ18 RQ22
        nxt_st.flags_one_r[`ICFL_F1_RECEIVE] = serial_receive_full; // RQ19
        nxt_st.flags_one_r[`ICFL_F1_TRANSMIT] = serial_transmit_empty; // RQ20
        if (SMALL_PACKAGE)
        begin
            nxt_st.flags_one_r[`ICFL_F1_PARALLEL] = 1'b0; // RQ17
        end
        // Taking an interrupt drops the enable that let it through
        if (st_ff.irq_req & irq_ack)
        begin
            if (st_ff.prio_en & ~st_ff.irq_high)
            begin
                nxt_st.main_r[`ICFL_MAIN_PERIPH_LOW] = 1'b0; // RQ26
            end
            else
            begin
                nxt_st.main_r[`ICFL_MAIN_GLOBAL_HIGH] = 1'b0; // RQ26
            end
        end
        // Read channel: one cycle from address to data
        if (st_ff.rvalid & s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid & st_ff.arready)
        begin
            rd_hit = 1'b1;
            case (s_axi_araddr)
                `ICFL_OFF_MAIN: rd_val = st_ff.main_r;
                `ICFL_OFF_EDGE_PRIO: rd_val = st_ff.edge_prio_r & `ICFL_MASK_EDGE_PRIO; // RQ14
                `ICFL_OFF_EXTERNAL: rd_val = st_ff.external_r & `ICFL_MASK_EXTERNAL; // RQ14
                `ICFL_OFF_FLAGS_ONE: rd_val = st_ff.flags_one_r;
                `ICFL_OFF_RESET_CTRL: rd_val = {st_ff.prio_en, 7'h00};
                `ICFL_OFF_PERIPH_EN: rd_val = st_ff.periph_en_r;
                `ICFL_OFF_PERIPH_PRIO: rd_val = st_ff.periph_prio_r;
                `ICFL_OFF_STATUS: rd_val = {6'h00, st_ff.irq_high, st_ff.irq_req};
                default: rd_hit = 1'b0;
            endcase
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {24'h000000, rd_val};
            nxt_st.rresp = rd_hit ? `ICFL_RESP_OKAY : `ICFL_RESP_SLVERR;
        end
        nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
        nxt_st.wready = ~nxt_st.w_got & ~nxt_st.bvalid;
        nxt_st.arready = ~nxt_st.rvalid;
        // Pull-ups follow the port latches unless disabled as a group
        nxt_st.pullup_on = nxt_st.edge_prio_r[`ICFL_EP_PULLUP_DIS] ? 4'h0 : port_latch; // RQ9
        // Request evaluation on the next register values, so an ack drops it at once
        core_pend[0] = nxt_st.main_r[`ICFL_MAIN_T0_FLAG] & nxt_st.main_r[`ICFL_MAIN_T0_EN]; // RQ5
        core_pend[1] = nxt_st.main_r[`ICFL_MAIN_X0_FLAG] & nxt_st.main_r[`ICFL_MAIN_X0_EN]; // RQ5
        core_pend[2] = nxt_st.main_r[`ICFL_MAIN_PC_FLAG] & nxt_st.main_r[`ICFL_MAIN_PC_EN]; // RQ5
        core_pend[3] = nxt_st.external_r[`ICFL_EX_X1_FLAG] & nxt_st.external_r[`ICFL_EX_X1_EN]; // RQ12
        core_pend[4] = nxt_st.external_r[`ICFL_EX_X2_FLAG] & nxt_st.external_r[`ICFL_EX_X2_EN]; // RQ12
        // Ext zero has no priority bit and always ranks high
        core_prio = {nxt_st.external_r[`ICFL_EX_X2_PRIO], nxt_st.external_r[`ICFL_EX_X1_PRIO],
            nxt_st.edge_prio_r[`ICFL_EP_PC_PRIO], 1'b1, nxt_st.edge_prio_r[`ICFL_EP_T0_PRIO]}; // RQ11
        per_pend = nxt_st.flags_one_r & nxt_st.periph_en_r;
        any_hi = |(core_pend & core_prio) | |(per_pend & nxt_st.periph_prio_r); // RQ11
        any_lo = |(core_pend & ~core_prio) | |(per_pend & ~nxt_st.periph_prio_r); // RQ11
        any_compat = |core_pend | (nxt_st.main_r[`ICFL_MAIN_PERIPH_LOW] & |per_pend); // RQ3
        if (nxt_st.prio_en) // RQ23
        begin
            nxt_st.irq_high = nxt_st.main_r[`ICFL_MAIN_GLOBAL_HIGH] & any_hi; // RQ2
            nxt_st.irq_req = nxt_st.main_r[`ICFL_MAIN_GLOBAL_HIGH] &
                (any_hi | (nxt_st.main_r[`ICFL_MAIN_PERIPH_LOW] & any_lo)); // RQ2 RQ4
            nxt_st.irq_vector = nxt_st.irq_high ? `ICFL_VEC_HIGH : `ICFL_VEC_LOW; // RQ24
        end
        else
        begin
            nxt_st.irq_high = 1'b1;
            nxt_st.irq_req = nxt_st.main_r[`ICFL_MAIN_GLOBAL_HIGH] & any_compat; // RQ1
            nxt_st.irq_vector = `ICFL_VEC_HIGH; // RQ25
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
            st_ff.main_r <= `ICFL_RST_MAIN;
            st_ff.edge_prio_r <= `ICFL_RST_EDGE_PRIO;
            st_ff.external_r <= `ICFL_RST_EXTERNAL;
            st_ff.flags_one_r <= `ICFL_RST_FLAGS_ONE;
            st_ff.periph_en_r <= `ICFL_RST_PERIPH_EN;
            st_ff.periph_prio_r <= `ICFL_RST_PERIPH_PRIO;
            st_ff.irq_vector <= `ICFL_VEC_HIGH;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign irq_request = st_ff.irq_req;
    assign irq_high = st_ff.irq_high;
    assign irq_vector = st_ff.irq_vector;
    assign pullup_on = st_ff.pullup_on;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ack_taken;
        irq_request && irq_ack && !st_ff.prio_en;
    endsequence

    property p_gie_blocks;
        !st_ff.prio_en && !st_ff.main_r[`ICFL_MAIN_GLOBAL_HIGH] |-> !irq_request;
    endproperty
    a_gie_blocks: assert property (p_gie_blocks) // RQ1
        else $error("request raised with global enable clear");

    property p_high_passes;
        st_ff.prio_en && st_ff.main_r[7] && (st_ff.main_r[5:4] == 2'h1) && st_ff.main_r[1]
            |-> irq_request && irq_high && (irq_vector == `ICFL_VEC_HIGH);
    endproperty
    a_high_passes: assert property (p_high_passes) // RQ2
        else $error("enabled high source not requested on high vector");

    property p_peie_blocks;
        !st_ff.prio_en && !st_ff.main_r[6] && (st_ff.main_r[5:3] == 3'h0)
            && (st_ff.external_r[4:3] == 2'h0) |-> !irq_request;
    endproperty
    a_peie_blocks: assert property (p_peie_blocks) // RQ3
        else $error("peripheral request passed with peripheral enable clear");

    property p_low_blocked;
        st_ff.prio_en && !st_ff.main_r[6] |-> !irq_request || irq_high;
    endproperty
    a_low_blocked: assert property (p_low_blocked) // RQ4
        else $error("low request passed with low enable clear");

    property p_t0_flag;
        timer_zero_overflow |=> st_ff.main_r[`ICFL_MAIN_T0_FLAG];
    endproperty
    a_t0_flag: assert property (p_t0_flag) // RQ6
        else $error("timer zero flag not set after overflow");

    property p_x0_rise;
        st_ff.edge_prio_r[6] && st_ff.ext_s2[0] && !st_ff.ext_prev[0] |=> st_ff.main_r[1];
    endproperty
    a_x0_rise: assert property (p_x0_rise) // RQ10
        else $error("rising edge on ext zero not flagged");

    property p_unimpl_zero;
        !st_ff.edge_prio_r[3] && !st_ff.edge_prio_r[1]
            && !st_ff.external_r[5] && !st_ff.external_r[2];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) // RQ14
        else $error("unimplemented control bit set");

    property p_rx_mirror;
        ##1 st_ff.flags_one_r[`ICFL_F1_RECEIVE] == $past(serial_receive_full);
    endproperty
    a_rx_mirror: assert property (p_rx_mirror) // RQ19
        else $error("receive flag does not follow buffer full");

    property p_ack_clears;
        s_ack_taken |=> !st_ff.main_r[`ICFL_MAIN_GLOBAL_HIGH] && !irq_request;
    endproperty
    a_ack_clears: assert property (p_ack_clears) // RQ26
        else $error("global enable not cleared on interrupt taken");

    property p_compat_vector;
        !st_ff.prio_en && irq_request |-> irq_vector == `ICFL_VEC_HIGH;
    endproperty
    a_compat_vector: assert property (p_compat_vector) // RQ25
        else $error("compat mode request not on high vector");

endmodule // icfl_top
`default_nettype wire

/* File: verification/icfl_far_model.sv */
// Model of the peripheral event sources and of the core that takes interrupts
`timescale 1ns/1ps
`default_nettype none
module icfl_far_model (
    // Clock
    input wire logic aclk,
    // Bench commands
    input wire logic [6:0] fire,
    input wire logic ack_en,
    // Design side
    input wire logic irq_request,
    output logic [6:0] ev,
    output logic irq_ack
);
    // One-cycle event pulses; ack only a live request, never twice in a row
    // Both outputs settle at the first edge, well inside the reset
    always @(posedge aclk)
    begin
        ev <= fire;
        irq_ack <= ack_en & irq_request & ~irq_ack;
    end
endmodule // icfl_far_model
`default_nettype wire

/* File: verification/interrupt_control_flag_logic_tb_top.sv */
// Self-checking bench for the interrupt flag logic
`timescale 1ns/1ps
`default_nettype none
module interrupt_control_flag_logic_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] aa = 8'h00;
    logic [7:0] ra = 8'h00;
    logic [31:0] wd = 32'h0;
    logic av = 1'b0, wv = 1'b0, br = 1'b0, rv = 1'b0, rr = 1'b0;
    logic ar, wr_rdy, bv, arr, rvl, irq, ih, ack, pread = 1'b0, rxf = 1'b0, txe = 1'b0;
    logic ack_en = 1'b0;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, got;
    logic [2:0] pins = 3'h0;
    logic [3:0] up = 4'h0, latch = 4'hA, pu;
    logic [15:0] vec;
    logic [6:0] fire = 7'h00, ev;
    icfl_pkg::icfl_ccp_mode_t mode = icfl_pkg::CCP_CAPTURE;
    int fails = 0, checks_done = 0;
    icfl_top icfl_top_inst (.aclk, .aresetn, .s_axi_awaddr(aa), .s_axi_awvalid(av),
        .s_axi_awready(ar), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ra), .s_axi_arvalid(rv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr), .ext_irq_pins(pins),
        .upper_port_inputs(up), .timer_zero_overflow(ev[6]), .port_read(pread),
        .port_latch(latch), .parallel_port_done(ev[5]), .converter_done(ev[4]),
        .serial_receive_full(rxf), .serial_transmit_empty(txe), .sync_serial_done(ev[3]),
        .capcomp_event(ev[2]), .capcomp_mode(mode), .timer_two_match(ev[1]),
        .timer_one_overflow(ev[0]), .irq_ack(ack), .irq_request(irq), .irq_high(ih),
        .irq_vector(vec), .pullup_on(pu));
    icfl_far_model icfl_far_model_inst (.aclk, .fire, .ack_en, .irq_request(irq), .ev,
        .irq_ack(ack));
    // 125 MHz core clock
    always #4 aclk = ~aclk;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Readies and valids are sampled as they stood at the edge
    // No wait limit here: only the watchdog ends a hung transfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        aa <= a;
        wd <= d;
        av <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (ar) av <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (!bv);
        rs = bresp;
        br <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        ra <= a;
        rv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arr) rv <= 1'b0;
        end while (!rvl);
        got = rdata;
        rs = rresp;
        rr <= 1'b0;
    endtask
    // Event pulse through the source model, then let the flag land
    task automatic pulse(input logic [6:0] m);
        @(posedge aclk);
        fire <= m;
        @(posedge aclk);
        fire <= 7'h00;
        repeat (3) @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_map();
        rd(8'h04); chk(got, 32'hF5);
        rd(8'h08); chk(got, 32'hC0);
        chk(pu, 32'h0);
        rd(8'h20); chk(rs, 32'h2);
        wr(8'h20, 32'h0); chk(rs, 32'h2);
        wr(8'h08, 32'hFF); chk(rs, 32'h0);
        rd(8'h08); chk(got, 32'hDB);
        wr(8'h04, 32'hFF); rd(8'h04); chk(got, 32'hF5);
        wr(8'h04, 32'h75); repeat (2) @(posedge aclk); chk(pu, 32'hA);
        wr(8'h04, 32'hF5);
        wr(8'h08, 32'hC0);
    endtask
    task automatic t_flags();
        pulse(7'h7F); rd(8'h0C); chk(got, 32'hCF);
        rd(8'h00); chk(got, 32'h04);
        rxf <= 1'b1;
        txe <= 1'b1;
        wr(8'h0C, 32'h00); rd(8'h0C); chk(got, 32'h30);
        rxf <= 1'b0;
        txe <= 1'b0;
        mode <= icfl_pkg::CCP_PWM;
        pulse(7'h04); rd(8'h0C); chk(got, 32'h00);
        mode <= icfl_pkg::CCP_COMPARE;
        pulse(7'h04); rd(8'h0C); chk(got, 32'h04);
        wr(8'h0C, 32'h00);
        mode <= icfl_pkg::CCP_CAPTURE;
    endtask
    task automatic t_compat_irq();
        wr(8'h00, 32'hA0);
        pulse(7'h40); chk({irq, ih, vec}, {14'h0, 18'h30008});
        rd(8'h1C); chk(got, 32'h3);
        ack_en <= 1'b1;
        repeat (4) @(posedge aclk);
        ack_en <= 1'b0;
        chk(irq, 32'h0);
        rd(8'h00); chk(got, 32'h24);
    endtask
    task automatic t_priority();
        wr(8'h10, 32'h80);
        rd(8'h10); chk(got, 32'h80);
        wr(8'h04, 32'hF1);
        wr(8'h00, 32'hA0);
        pulse(7'h40); chk(irq, 32'h0);
        wr(8'h00, 32'hE4); repeat (2) @(posedge aclk);
        chk({irq, ih, vec}, {14'h0, 18'h20018});
        wr(8'h10, 32'h00);
        wr(8'h04, 32'hF5);
        wr(8'h00, 32'h00);
    endtask
    task automatic t_pins();
        pins <= 3'h2;
        repeat (6) @(posedge aclk);
        rd(8'h08); chk(got, 32'hC1);
        wr(8'h08, 32'hC0);
        wr(8'h04, 32'hD5);
        pins <= 3'h0;
        repeat (6) @(posedge aclk);
        rd(8'h08); chk(got, 32'hC1);
        up <= 4'h1;
        repeat (6) @(posedge aclk);
        wr(8'h00, 32'h00); rd(8'h00); chk(got, 32'h01);
        pread <= 1'b1;
        @(posedge aclk);
        pread <= 1'b0;
        repeat (2) @(posedge aclk);
        wr(8'h00, 32'h00); rd(8'h00); chk(got, 32'h00);
    endtask
    // Ext zero in priority mode, then a peripheral source in compat mode
    task automatic t_ext_zero();
        wr(8'h10, 32'h80);
        wr(8'h00, 32'h90);
        pins <= 3'h1;
        repeat (6) @(posedge aclk);
        chk({irq, ih, vec}, {14'h0, 18'h30008});
        rd(8'h00); chk(got, 32'h92);
        ack_en <= 1'b1;
        repeat (4) @(posedge aclk);
        ack_en <= 1'b0;
        rd(8'h00); chk(got, 32'h12);
        wr(8'h10, 32'h00);
        wr(8'h14, 32'h01);
        wr(8'h00, 32'hC0);
        pulse(7'h01); chk(irq, 32'h1);
        wr(8'h00, 32'h80); repeat (2) @(posedge aclk); chk(irq, 32'h0);
    endtask
    // Main sequence after 12 cycles of reset
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_map();
        t_flags();
        t_compat_irq();
        t_priority();
        t_pins();
        t_ext_zero();
        tally_and_finish();
    end
    // Watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end
endmodule // interrupt_control_flag_logic_tb_top
`default_nettype wire
